/* File: bench/rfc_osc_model.sv */
// Behavioural model of the two oscillator sources feeding the converter.
// Assumes half periods of at least three aclk cycles so the pin syncs see every edge.
`timescale 1ns/1ps
`default_nettype none
module rfc_osc_model #(
    parameter int FAST_HALF = 3,
    parameter int SLOW_HALF = 50
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic fast_osc_source,
    output logic slow_osc_source
);
    int fast_cnt;
    int slow_cnt;

    // Both sources run free, as crystal or RC oscillators do; only their rates differ.
    // The slow rate is far below the fast one so the chosen source shows in the count rate.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fast_cnt <= 0;
            slow_cnt <= 0;
            fast_osc_source <= 1'b0;
            slow_osc_source <= 1'b0;
        end else begin
            fast_cnt <= (fast_cnt == FAST_HALF - 1) ? 0 : fast_cnt + 1;
            slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
            if (fast_cnt == FAST_HALF - 1) fast_osc_source <= !fast_osc_source;
            if (slow_cnt == SLOW_HALF - 1) slow_osc_source <= !slow_osc_source;
        end
    end
endmodule // rfc_osc_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench of the converter control block over AXI4-Lite.
// Assumes the oscillator model drives both source pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rfc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [RFC_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic fast_osc, slow_osc, ref_en, sen_en, ch1_sel, ch1_ac, irq;
    int n_errors = 0;
    int checks = 0;
    logic [31:0] seed = 32'h00012887;

    // The clock toggles every half period of 10 ns.
    always #10 aclk = !aclk;

    rfc_control i_rfc_control (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fast_osc_source(fast_osc),
        .slow_osc_source(slow_osc), .ref_osc_en(ref_en), .sensor_osc_en(sen_en),
        .ch1_select(ch1_sel), .ch1_ac_mode(ch1_ac), .irq(irq));

    rfc_osc_model i_rfc_osc_model (.aclk(aclk), .aresetn(aresetn),
        .fast_osc_source(fast_osc), .slow_osc_source(slow_osc));

    // Galois shift register gives repeatable stimulus from the fixed seed.
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            n_errors++;
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Write master: address and data offered together, each dropped when taken.
    task automatic axi_wr(input logic [15:0] idx, input logic [3:0] d, input logic [3:0] strb,
                          output logic [1:0] resp);
        bit aw_p, w_p, done;
        aw_p = 1;
        w_p = 1;
        done = 0;
        @(posedge aclk);
        awaddr <= {idx, 2'b00};
        awvalid <= 1'b1;
        wdata <= {lfsr_next(seed) & 32'hFFFFFFF0} | {28'h0, d};
        wstrb <= strb;
        wvalid <= 1'b1;
        bready <= 1'b1;
        seed = lfsr_next(seed);
        while (!done) begin
            @(posedge aclk);
            if (aw_p && awready) begin aw_p = 0; awvalid <= 1'b0; end
            if (w_p && wready) begin w_p = 0; wvalid <= 1'b0; end
            if (bready && bvalid) begin done = 1; resp = bresp; bready <= 1'b0; end
        end
    endtask

    task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] resp);
        bit a_p, done;
        a_p = 1;
        done = 0;
        @(posedge aclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (a_p && arready) begin a_p = 0; arvalid <= 1'b0; end
            if (rready && rvalid) begin done = 1; d = rdata; resp = rresp; rready <= 1'b0; end
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [3:0] d);
        logic [1:0] r;
        axi_wr(idx, d, 4'hF, r);
        chk($sformatf("bresp_%h", idx), {30'h0, RFC_RESP_OKAY}, {30'h0, r});
    endtask

    task automatic rd_chk(input logic [15:0] idx, input logic [3:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(idx, d, r);
        chk($sformatf("reg_%h", idx), {28'h0, exp}, d);
        chk($sformatf("rresp_%h", idx), {30'h0, RFC_RESP_OKAY}, {30'h0, r});
    endtask

    // Outputs are looked at one cycle after the write answer, once settled.
    task automatic out_chk(input logic [4:0] exp);
        @(posedge aclk);
        #1;
        chk("outputs", {27'h0, exp}, {27'h0, ch1_sel, ch1_ac, ref_en, sen_en, irq});
    endtask

    // Polls the run and status word until the overflow flag shows, or gives up.
    task automatic wait_ovf(input int max_reads, output bit seen);
        logic [31:0] d;
        logic [1:0] r;
        seen = 0;
        for (int i = 0; i < max_reads && !seen; i++) begin
            axi_rd(RFC_IDX_RUN, d, r);
            seen = d[RFC_RUN_MEAS_OVF];
        end
    endtask

    // A hang is cut short well past the expected run of a few thousand cycles.
    initial begin
        repeat (30000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    initial begin
        logic [3:0] v;
        logic [7:0] cnt;
        logic [31:0] d;
        logic [1:0] r;
        bit seen;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values of the control, run and interrupt registers and of every output.
        rd_chk(RFC_IDX_CONTROL, 4'h0);
        rd_chk(RFC_IDX_RUN, 4'h0);
        rd_chk(RFC_IDX_IRQ_STATUS, 4'h0);
        rd_chk(RFC_IDX_IRQ_MASK, 4'h0);
        out_chk(5'h00);
        wr(RFC_IDX_RUN, 4'h0);
        rd_chk(RFC_IDX_RUN, 4'h0);
        $display("test reset done");
        // Counter nibbles are loaded and read back while no oscillation runs.
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_next(seed);
            cnt = seed[7:0];
            wr(RFC_IDX_NIB0, cnt[3:0]);
            wr(RFC_IDX_NIB1, cnt[7:4]);
            rd_chk(RFC_IDX_NIB0, cnt[3:0]);
            rd_chk(RFC_IDX_NIB1, cnt[7:4]);
        end
        $display("test counter nibbles done");
        // Every control code, then random ones; bit 3 always reads zero.
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_next(seed);
            v = (i < 8) ? i[3:0] : seed[3:0];
            wr(RFC_IDX_CONTROL, v);
            rd_chk(RFC_IDX_CONTROL, v & 4'h7);
            out_chk({v[0], v[1], 3'b000});
        end
        axi_wr(RFC_IDX_CONTROL, 4'h0, 4'h0, r);
        chk("bresp_nostrb", {30'h0, RFC_RESP_OKAY}, {30'h0, r});
        rd_chk(RFC_IDX_CONTROL, v & 4'h7);
        $display("test control done");
        // Unmapped index refuses with an error and reads zero.
        axi_wr(16'hFF94, 4'hF, 4'hF, r);
        chk("bresp_unmapped", {30'h0, RFC_RESP_SLVERR}, {30'h0, r});
        axi_rd(16'hFF94, d, r);
        chk("rresp_unmapped", {30'h0, RFC_RESP_SLVERR}, {30'h0, r});
        chk("rdata_unmapped", 32'h0, d);
        $display("test unmapped done");
        // Slow source chosen: reference run, zero write ignored, no early overflow.
        wr(RFC_IDX_NIB0, 4'h0);
        wr(RFC_IDX_NIB1, 4'hF);
        wr(RFC_IDX_CONTROL, 4'h0);
        wr(RFC_IDX_RUN, 4'h2);
        wr(RFC_IDX_RUN, 4'h0);
        rd_chk(RFC_IDX_RUN, 4'h2);
        out_chk(5'h04);
        wait_ovf(40, seen);
        chk("ovf_slow_early", 32'h0, {31'h0, seen});
        wait_ovf(800, seen);
        chk("ovf_slow", 32'h1, {31'h0, seen});
        rd_chk(RFC_IDX_RUN, 4'h4);
        wr(RFC_IDX_RUN, 4'h4);
        rd_chk(RFC_IDX_RUN, 4'h0);
        wr(RFC_IDX_IRQ_STATUS, 4'h3);
        $display("test slow source done");
        // Fast source chosen: sensor run overflows quickly and raises the interrupt.
        wr(RFC_IDX_NIB0, 4'h0);
        wr(RFC_IDX_NIB1, 4'hF);
        wr(RFC_IDX_CONTROL, 4'h4);
        wr(RFC_IDX_IRQ_MASK, 4'h1);
        wr(RFC_IDX_RUN, 4'h1);
        wr(RFC_IDX_RUN, 4'h0);
        rd_chk(RFC_IDX_RUN, 4'h1);
        out_chk(5'h02);
        wait_ovf(60, seen);
        chk("ovf_fast", 32'h1, {31'h0, seen});
        rd_chk(RFC_IDX_RUN, 4'h4);
        rd_chk(RFC_IDX_IRQ_STATUS, 4'h3);
        out_chk(5'h01);
        wr(RFC_IDX_IRQ_MASK, 4'h0);
        out_chk(5'h00);
        wr(RFC_IDX_IRQ_MASK, 4'h1);
        out_chk(5'h01);
        wr(RFC_IDX_IRQ_STATUS, 4'h1);
        rd_chk(RFC_IDX_IRQ_STATUS, 4'h2);
        out_chk(5'h00);
        wr(RFC_IDX_IRQ_MASK, 4'h3);
        out_chk(5'h01);
        wr(RFC_IDX_IRQ_STATUS, 4'h2);
        out_chk(5'h00);
        $display("test fast source done");
        summarize();
    end
endmodule // tb
`default_nettype wire

/* File: rtl/rfc_cnt_if.sv */
// Link between the register control and the measurement counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rfc_cnt_if #(parameter int W = 8);
    // Nibble selector; W must hold at least two nibbles.
    logic count_pulse;
    logic load_en;
    logic [$clog2(W/4)-1:0] load_sel;
    logic [3:0] load_data;
    logic [W-1:0] value;
    logic ovf_pulse;
    modport ctrl (output count_pulse, output load_en, output load_sel, output load_data,
                  input value, input ovf_pulse);
    modport cnt (input count_pulse, input load_en, input load_sel, input load_data,
                 output value, output ovf_pulse);
endinterface
`default_nettype wire

/* File: rtl/rfc_control.sv */
// R/F converter control: AXI4-Lite registers, oscillator run control,
// clock source choice, overflow flag and interrupt.
// Assumes oscillator pins are asynchronous and slower than aclk / 4.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rfc_control import rfc_pkg::*; #(
    parameter int MEAS_W = RFC_MEAS_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [RFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [RFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fast_osc_source,
    input wire logic slow_osc_source,
    output logic ref_osc_en,
    output logic sensor_osc_en,
    output logic ch1_select,
    output logic ch1_ac_mode,
    output logic irq
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_full;
        logic w_full;
        logic [15:0] aw_idx;
        logic [RFC_NIB_W-1:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic conv_clock_select;
        logic ch1_sensor_type;
        logic input_channel_select;
        logic ref_osc_run;
        logic sensor_osc_run;
        logic meas_count_overflow;
        logic [RFC_EV_W-1:0] irq_status;
        logic [RFC_EV_W-1:0] irq_mask;
        logic irq;
        logic count_pulse;
        logic load_en;
        logic [$clog2(MEAS_W/4)-1:0] load_sel;
        logic [RFC_NIB_W-1:0] load_data;
    } rfc_state_t;

    rfc_state_t s_reg, s_next;
    logic fast_rise;
    logic slow_rise;
    logic conv_edge;
    logic wr_now;
    logic [RFC_EV_W-1:0] events;
    logic [15:0] rd_idx;
    logic [RFC_NIB_W-1:0] wr_nib;

    rfc_cnt_if #(.W(MEAS_W)) cnt_link ();

    // Both oscillator pins are synchronised; only their rising edges count.
    rfc_pin_sync fast_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(fast_osc_source),
        .rise(fast_rise)
    );

    rfc_pin_sync slow_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(slow_osc_source),
        .rise(slow_rise)
    );

    rfc_meas_counter #(.W(MEAS_W)) meas_counter (
        .aclk(aclk),
        .aresetn(aresetn),
        .cnt(cnt_link.cnt)
    );

    // Selected conversion clock edge and the write that completes this cycle.
    assign conv_edge = s_reg.conv_clock_select ? fast_rise : slow_rise;
    assign wr_now = s_reg.aw_full & s_reg.w_full;
    assign rd_idx = s_axi_araddr[RFC_ADDR_W-1:2];
    assign wr_nib = s_reg.wdata;

    // Hardware events that feed the sticky interrupt status.
    assign events[RFC_EV_OVF] = cnt_link.ovf_pulse;
    assign events[RFC_EV_STOP] = cnt_link.ovf_pulse &
                                 (s_reg.ref_osc_run | s_reg.sensor_osc_run);

    // Next state of the bus slave, the control bits and the counter link.
    // Hardware sets are applied after software clears so that an event in
    // the clearing cycle survives; a software start beats a hardware stop.
    always_comb begin
        s_next = s_reg;
        s_next.load_en = 1'b0;

        // Address and data are taken independently, in either order.
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.aw_full = 1'b1;
            s_next.aw_idx = s_axi_awaddr[RFC_ADDR_W-1:2];
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.w_full = 1'b1;
            s_next.wdata = s_axi_wdata[RFC_NIB_W-1:0];
            s_next.wstrb0 = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end

        // Count only while an oscillation runs, on the chosen source.
        s_next.count_pulse = conv_edge & (s_reg.ref_osc_run | s_reg.sensor_osc_run);

        // Counter overflow ends the measurement and raises the flag.
        if (cnt_link.ovf_pulse) begin
            s_next.ref_osc_run = 1'b0;
            s_next.sensor_osc_run = 1'b0;
        end

        // Register writes once both halves have arrived.
        if (wr_now) begin
            s_next.aw_full = 1'b0;
            s_next.w_full = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RFC_RESP_OKAY;
            case (s_reg.aw_idx)
                RFC_IDX_CONTROL: begin
                    if (s_reg.wstrb0) begin
                        s_next.input_channel_select = wr_nib[RFC_CTL_INPUT_SEL];
                        s_next.ch1_sensor_type = wr_nib[RFC_CTL_CH1_TYPE];
                        s_next.conv_clock_select = wr_nib[RFC_CTL_CLK_SEL];
                    end
                end
                RFC_IDX_RUN: begin
                    if (s_reg.wstrb0) begin
                        // Zero writes leave the run bits alone.
                        if (wr_nib[RFC_RUN_REF]) begin
                            s_next.ref_osc_run = 1'b1;
                        end
                        if (wr_nib[RFC_RUN_SENSOR]) begin
                            s_next.sensor_osc_run = 1'b1;
                        end
                        if (wr_nib[RFC_RUN_MEAS_OVF]) begin
                            s_next.meas_count_overflow = 1'b0;
                        end
                    end
                end
                RFC_IDX_NIB0, RFC_IDX_NIB1: begin
                    s_next.load_en = s_reg.wstrb0;
                    s_next.load_sel = (s_reg.aw_idx == RFC_IDX_NIB1) ? 1'b1 : 1'b0;
                    s_next.load_data = wr_nib;
                end
                RFC_IDX_IRQ_STATUS: begin
                    if (s_reg.wstrb0) begin
                        s_next.irq_status = s_reg.irq_status & ~wr_nib[RFC_EV_W-1:0];
                    end
                end
                RFC_IDX_IRQ_MASK: begin
                    if (s_reg.wstrb0) begin
                        s_next.irq_mask = wr_nib[RFC_EV_W-1:0];
                    end
                end
                default: begin
                    s_next.bresp = RFC_RESP_SLVERR;
                end
            endcase
        end

        // Sticky sets after the clears, so the event wins.
        if (cnt_link.ovf_pulse) begin
            s_next.meas_count_overflow = 1'b1;
        end
        s_next.irq_status = s_next.irq_status | events;

        // Reads answer one cycle after the address is taken.
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && s_axi_arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RFC_RESP_OKAY;
            s_next.rdata = 32'h0;
            case (rd_idx)
                RFC_IDX_CONTROL: begin
                    s_next.rdata[RFC_CTL_INPUT_SEL] = s_reg.input_channel_select;
                    s_next.rdata[RFC_CTL_CH1_TYPE] = s_reg.ch1_sensor_type;
                    s_next.rdata[RFC_CTL_CLK_SEL] = s_reg.conv_clock_select;
                end
                RFC_IDX_RUN: begin
                    s_next.rdata[RFC_RUN_SENSOR] = s_reg.sensor_osc_run;
                    s_next.rdata[RFC_RUN_REF] = s_reg.ref_osc_run;
                    s_next.rdata[RFC_RUN_MEAS_OVF] = s_reg.meas_count_overflow;
                end
                RFC_IDX_NIB0: begin
                    s_next.rdata[RFC_NIB_W-1:0] = cnt_link.value[RFC_NIB_W-1:0];
                end
                RFC_IDX_NIB1: begin
                    s_next.rdata[RFC_NIB_W-1:0] = cnt_link.value[2*RFC_NIB_W-1:RFC_NIB_W];
                end
                RFC_IDX_IRQ_STATUS: begin
                    s_next.rdata[RFC_EV_W-1:0] = s_reg.irq_status;
                end
                RFC_IDX_IRQ_MASK: begin
                    s_next.rdata[RFC_EV_W-1:0] = s_reg.irq_mask;
                end
                default: begin
                    s_next.rresp = RFC_RESP_SLVERR;
                end
            endcase
        end

        // Ready flags are registered; they drop while a response is pending.
        s_next.awready = ~s_next.aw_full & ~s_next.bvalid;
        s_next.wready = ~s_next.w_full & ~s_next.bvalid;
        s_next.arready = ~s_next.rvalid;
        s_next.irq = |(s_next.irq_status & s_next.irq_mask);
    end

    // Synchronous reset clears every control bit and the bus handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Counter link and outputs, all taken straight from the state register.
    assign cnt_link.count_pulse = s_reg.count_pulse;
    assign cnt_link.load_en = s_reg.load_en;
    assign cnt_link.load_sel = s_reg.load_sel;
    assign cnt_link.load_data = s_reg.load_data;
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign ref_osc_en = s_reg.ref_osc_run;
    assign sensor_osc_en = s_reg.sensor_osc_run;
    assign ch1_select = s_reg.input_channel_select;
    assign ch1_ac_mode = s_reg.ch1_sensor_type;
    assign irq = s_reg.irq;

    // Checks of the documented behaviour against the registered state.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    clk_route_a: assert property (
        (s_reg.ref_osc_run | s_reg.sensor_osc_run) && !cnt_link.ovf_pulse &&
        (s_reg.conv_clock_select ? fast_rise : slow_rise)
        |=> cnt_link.count_pulse ##1 $changed(cnt_link.value))
        else $error("Selected oscillator edge was not counted.");

    chan_select_a: assert property (
        wr_now && s_reg.wstrb0 && s_reg.aw_idx == RFC_IDX_CONTROL
        |=> ch1_select == $past(wr_nib[RFC_CTL_INPUT_SEL]) &&
            ch1_ac_mode == $past(wr_nib[RFC_CTL_CH1_TYPE]))
        else $error("Channel or sensor type not taken from the write.");

    ovf_flag_a: assert property (
        $rose(s_reg.meas_count_overflow) |-> $past(cnt_link.ovf_pulse))
        else $error("Overflow flag set without a counter overflow.");

    ref_hold_a: assert property (
        wr_now && s_reg.aw_idx == RFC_IDX_RUN && !wr_nib[RFC_RUN_REF] &&
        ref_osc_en && !cnt_link.ovf_pulse
        |=> ref_osc_en)
        else $error("Writing zero stopped the reference oscillation.");

    sensor_start_a: assert property (
        wr_now && s_reg.wstrb0 && s_reg.aw_idx == RFC_IDX_RUN && wr_nib[RFC_RUN_SENSOR]
        |=> sensor_osc_en && s_axi_bvalid)
        else $error("Sensor oscillation did not start on a one write.");

    nibble_read_a: assert property (
        s_reg.arready && s_axi_arvalid && rd_idx == RFC_IDX_NIB0
        |=> s_axi_rvalid && s_axi_rdata[RFC_NIB_W-1:0] == $past(cnt_link.value[RFC_NIB_W-1:0]))
        else $error("Low counter nibble read back wrong.");

    nibble_load_a: assert property (
        wr_now && s_reg.wstrb0 && s_reg.aw_idx == RFC_IDX_NIB1
        |=> ##1 cnt_link.value[2*RFC_NIB_W-1:RFC_NIB_W] == $past(wr_nib, 2))
        else $error("High counter nibble not loaded.");

    irq_level_a: assert property (
        cnt_link.ovf_pulse && s_reg.irq_mask[RFC_EV_OVF] |=> irq)
        else $error("Unmasked overflow did not raise the interrupt.");

    ref_start_a: assert property (
        wr_now && s_reg.wstrb0 && s_reg.aw_idx == RFC_IDX_RUN && wr_nib[RFC_RUN_REF]
        |=> ref_osc_en)
        else $error("Reference oscillation did not start on a one write.");

    sensor_hold_a: assert property (
        wr_now && s_reg.aw_idx == RFC_IDX_RUN && !wr_nib[RFC_RUN_SENSOR] &&
        sensor_osc_en && !cnt_link.ovf_pulse
        |=> sensor_osc_en)
        else $error("Writing zero stopped the sensor oscillation.");

    ovf_set_a: assert property (
        cnt_link.ovf_pulse |=> s_reg.meas_count_overflow)
        else $error("Counter overflow did not set the flag.");

    // An overflow ends both oscillations unless software restarts one in that cycle.
    run_stop_a: assert property (
        cnt_link.ovf_pulse && !(wr_now && s_reg.wstrb0 && s_reg.aw_idx == RFC_IDX_RUN)
        |=> !ref_osc_en && !sensor_osc_en)
        else $error("Oscillation kept running after a counter overflow.");

    // Edges of the source that is not selected must never reach the counter.
    clk_ignore_a: assert property (
        (s_reg.conv_clock_select ? !fast_rise : !slow_rise) |=> !cnt_link.count_pulse)
        else $error("Edge of the unselected oscillator was counted.");

    // The level drops once nothing unmasked is pending and nothing new arrives.
    irq_drop_a: assert property (
        !(|(s_reg.irq_status & s_reg.irq_mask)) && !(|events) && !wr_now |=> !irq)
        else $error("Interrupt stayed high with nothing unmasked pending.");
endmodule // rfc_control
`default_nettype wire

/* File: rtl/rfc_meas_counter.sv */
// Measurement counter: counts conversion clock pulses, loads by nibble.
// Assumes the control side raises count and load pulses for one cycle.
`timescale 1ns/1ps
`default_nettype none
module rfc_meas_counter import rfc_pkg::*; #(
    parameter int W = RFC_MEAS_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    rfc_cnt_if.cnt cnt
);
    typedef struct packed {
        logic [W-1:0] value;
        logic ovf;
    } rfc_cnt_t;

    rfc_cnt_t s_reg, s_next;

    // A software load wins over a count in the same cycle, so the loaded
    // value is never bumped by one behind the writer's back.
    always_comb begin
        s_next = s_reg;
        s_next.ovf = 1'b0;
        if (cnt.load_en) begin
            s_next.value[cnt.load_sel*RFC_NIB_W +: RFC_NIB_W] = cnt.load_data;
        end else if (cnt.count_pulse) begin
            s_next.value = s_reg.value + {{(W-1){1'b0}}, 1'b1};
            s_next.ovf = &s_reg.value;
        end
    end

    // Contents are meaningless until software loads them; reset clears them anyway.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cnt.value = s_reg.value;
    assign cnt.ovf_pulse = s_reg.ovf;
endmodule // rfc_meas_counter
`default_nettype wire

/* File: rtl/rfc_pin_sync.sv */
// Two-stage synchroniser for an oscillator pin with a rising edge pulse.
// Assumes the pin toggles slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none
module rfc_pin_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin,
    output logic rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } rfc_sync_t;

    rfc_sync_t s_reg, s_next;

    // The first stage feeds only the second; the edge looks at later stages.
    always_comb begin
        s_next = s_reg;
        s_next.s1 = pin;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
    end

    // Synchronous reset of the whole chain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rise = s_reg.s2 & ~s_reg.s3;
endmodule // rfc_pin_sync
`default_nettype wire

/* File: rtl/rfc_pkg.sv */
// Shared constants of the R/F converter control block: register indexes,
// field positions, reset values and bus answers.
// Assumes a 32-bit AXI4-Lite bus where each register index is one word.
package rfc_pkg;

    // Register indexes; the byte address of each is four times its index.
    localparam int RFC_ADDR_W = 18;
    localparam logic [15:0] RFC_IDX_CONTROL = 16'hFF90;
    localparam logic [15:0] RFC_IDX_RUN = 16'hFF91;
    localparam logic [15:0] RFC_IDX_NIB0 = 16'hFF92;
    localparam logic [15:0] RFC_IDX_NIB1 = 16'hFF93;
    localparam logic [15:0] RFC_IDX_IRQ_STATUS = 16'hFFA0;
    localparam logic [15:0] RFC_IDX_IRQ_MASK = 16'hFFA1;

    // Field positions in the control register.
    localparam int RFC_CTL_INPUT_SEL = 0;
    localparam int RFC_CTL_CH1_TYPE = 1;
    localparam int RFC_CTL_CLK_SEL = 2;

    // Field positions in the run and status register.
    localparam int RFC_RUN_SENSOR = 0;
    localparam int RFC_RUN_REF = 1;
    localparam int RFC_RUN_MEAS_OVF = 2;

    // Interrupt status and mask bits.
    localparam int RFC_EV_W = 2;
    localparam int RFC_EV_OVF = 0;
    localparam int RFC_EV_STOP = 1;

    // Data widths and reset values.
    localparam int RFC_NIB_W = 4;
    localparam int RFC_MEAS_W = 8;
    localparam logic [RFC_NIB_W-1:0] RFC_NIB_RST = 4'h0;
    localparam logic [1:0] RFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RFC_RESP_SLVERR = 2'h2;

endpackage
